// *** rtl/gpio_wake_pkg.sv ***
// constants for the general-purpose port with wake-up
package gpio_wake_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  ADDR_DATA    = 3'h0;
  localparam logic [2:0]  ADDR_DIR     = 3'h1;
  localparam logic [2:0]  ADDR_PU      = 3'h2;
  localparam logic [2:0]  ADDR_WAKE    = 3'h3;
  localparam logic [2:0]  ADDR_STR     = 3'h4;
  localparam int          STR_BIT      = 0;
  localparam logic [7:0]  RST_DATA     = 8'hFF;
  localparam logic [7:0]  RST_DIR      = 8'hFF;
  localparam logic [7:0]  RST_PU       = 8'h00;
  localparam logic [7:0]  RST_WAKE     = 8'h00;
  localparam logic        RST_STR      = 1'b0;
  localparam logic [7:0]  MASK_4PIN    = 8'h0F;
  localparam logic [7:0]  MASK_8PIN    = 8'hFF;
endpackage : gpio_wake_pkg

// *** rtl/port_a_gpio_wakeup.sv ***
// general-purpose port with pull-up control and falling-edge wake-up
`timescale 1ns/1ps
module port_a_gpio_wakeup #(
  parameter bit EIGHT_PIN = 1'b1
) (
  input  wire logic       i_ref_clk,    // system clock, 200 MHz
  input  wire logic       i_nrst,       // async reset, active low
  input  wire logic [2:0] i_addr,       // register select
  input  wire logic       i_wr,         // write strobe
  input  wire logic [7:0] i_wdata,      // write data
  input  wire logic       i_rd,         // read strobe
  output logic      [7:0] o_rdata,      // read data, valid cycle after rd
  input  wire logic       i_low_power,  // core in sleep or idle
  input  wire logic [7:0] i_pin,        // pin levels from pads
  output logic      [7:0] o_pin_out,    // pad output value
  output logic      [7:0] o_pin_oe,     // pad drive enable, high drives
  output logic      [7:0] o_pullup_on,  // weak pull-up enable per pin
  output logic      [7:0] o_pullup_strong, // stronger pull-up per pin
  output logic            o_wake_req    // wake-up request pulse
);
  localparam logic [7:0] MASK = EIGHT_PIN ? gpio_wake_pkg::MASK_8PIN
                                          : gpio_wake_pkg::MASK_4PIN;

  // programmer-visible registers
  logic [7:0] port_data;
  logic [7:0] direction_ctrl;
  logic [7:0] pullup_enable;
  logic [7:0] wake_enable;
  logic       pullup_strength_sel;

  // next values of the registers
  logic [7:0] next_port_data;
  logic [7:0] next_direction_ctrl;
  logic [7:0] next_pullup_enable;
  logic [7:0] next_wake_enable;
  logic       next_pullup_strength_sel;

  // read port: selected word, masked views and the held result
  logic [7:0] next_rdata;
  logic [7:0] next_rdata_hold;
  logic [7:0] view_data;
  logic [7:0] view_dir;
  logic [7:0] view_pu;
  logic [7:0] view_wake;
  logic [7:0] view_str;

  // write strobes, one per register
  logic       wr_data;
  logic       wr_dir;
  logic       wr_pu;
  logic       wr_wake;
  logic       wr_str;

  // per-pin results gathered from the pin loop
  wire  [7:0] pin_level;
  wire  [7:0] is_input;
  wire  [7:0] read_value;
  wire  [7:0] pin_fell;
  wire  [7:0] wake_armed;
  wire  [7:0] fall;
  wire  [7:0] pullup_allowed;
  wire  [7:0] next_pin_out;
  wire  [7:0] next_pin_oe;
  wire  [7:0] next_pullup_on;
  wire  [7:0] next_pullup_strong;

  // wake request path
  logic       any_fall;
  logic       next_wake_req;

  // unmapped offsets raise no strobe, so writes there are dropped
  assign wr_data = i_wr && (i_addr == gpio_wake_pkg::ADDR_DATA);
  assign wr_dir  = i_wr && (i_addr == gpio_wake_pkg::ADDR_DIR);
  assign wr_pu   = i_wr && (i_addr == gpio_wake_pkg::ADDR_PU);
  assign wr_wake = i_wr && (i_addr == gpio_wake_pkg::ADDR_WAKE);
  assign wr_str  = i_wr && (i_addr == gpio_wake_pkg::ADDR_STR);

  // per-pin logic; pins above the variant's width are tied to zero
  for (genvar p = 0; p < gpio_wake_pkg::DATA_W; p++) begin : g_pin
    if (MASK[p]) begin : g_used
      logic meta;
      logic sync;
      logic prev;

      // levels reset low so no falling edge is seen at release
      // first stage
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          meta <= 1'b0;
        end else begin
          meta <= i_pin[p];
        end
      end

      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          sync <= 1'b0;
        end else begin
          sync <= meta;
        end
      end

      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          prev <= 1'b0;
        end else begin
          prev <= sync;
        end
      end

      assign pin_level[p] = sync;

      assign is_input[p] = direction_ctrl[p];

      assign read_value[p] = is_input[p] ? pin_level[p] : port_data[p];

      // high then low is a falling edge
      assign pin_fell[p] = prev & ~sync;

      assign wake_armed[p] = wake_enable[p] & is_input[p];
      assign fall[p]       = pin_fell[p] & wake_armed[p];

      assign next_pin_out[p] = port_data[p];
      assign next_pin_oe[p]  = ~is_input[p];

      assign pullup_allowed[p] = is_input[p];
      assign next_pullup_on[p] = pullup_enable[p] & pullup_allowed[p];

      // strength only where pull-up is on
      assign next_pullup_strong[p] = next_pullup_on[p] & pullup_strength_sel;
    end else begin : g_unused
      assign pin_level[p]          = 1'b0;
      assign is_input[p]           = 1'b0;
      assign read_value[p]         = 1'b0;

      // absent pins never wake
      assign pin_fell[p]           = 1'b0;
      assign wake_armed[p]         = 1'b0;
      assign fall[p]               = 1'b0;

      // absent pins never drive or pull
      assign pullup_allowed[p]     = 1'b0;
      assign next_pin_out[p]       = 1'b0;
      assign next_pin_oe[p]        = 1'b0;
      assign next_pullup_on[p]     = 1'b0;
      assign next_pullup_strong[p] = 1'b0;
    end
  end

  // latch changes only on a port write
  always_comb begin
    next_port_data = port_data;
    if (wr_data) begin
      next_port_data = i_wdata & MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      port_data <= gpio_wake_pkg::RST_DATA & MASK;
    end else begin
      port_data <= next_port_data;
    end
  end

  always_comb begin
    next_direction_ctrl = direction_ctrl;
    if (wr_dir) begin
      next_direction_ctrl = i_wdata & MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      direction_ctrl <= gpio_wake_pkg::RST_DIR & MASK;
    end else begin
      direction_ctrl <= next_direction_ctrl;
    end
  end

  always_comb begin
    next_pullup_enable = pullup_enable;
    if (wr_pu) begin
      next_pullup_enable = i_wdata & MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pullup_enable <= gpio_wake_pkg::RST_PU;
    end else begin
      pullup_enable <= next_pullup_enable;
    end
  end

  always_comb begin
    next_wake_enable = wake_enable;
    if (wr_wake) begin
      next_wake_enable = i_wdata & MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wake_enable <= gpio_wake_pkg::RST_WAKE;
    end else begin
      wake_enable <= next_wake_enable;
    end
  end

  // strength select, one bit for all pins
  always_comb begin
    next_pullup_strength_sel = pullup_strength_sel;
    if (wr_str) begin
      next_pullup_strength_sel = i_wdata[gpio_wake_pkg::STR_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pullup_strength_sel <= gpio_wake_pkg::RST_STR;
    end else begin
      pullup_strength_sel <= next_pullup_strength_sel;
    end
  end

  always_comb begin
    view_data = read_value & MASK;
    view_dir  = direction_ctrl & MASK;
    view_pu   = pullup_enable & MASK;
    view_wake = wake_enable & MASK;
    view_str  = {7'h00, pullup_strength_sel};
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (i_addr)
      gpio_wake_pkg::ADDR_DATA: begin
        next_rdata = view_data;
      end
      gpio_wake_pkg::ADDR_DIR: begin
        next_rdata = view_dir;
      end
      gpio_wake_pkg::ADDR_PU: begin
        next_rdata = view_pu;
      end
      gpio_wake_pkg::ADDR_WAKE: begin
        next_rdata = view_wake;
      end
      gpio_wake_pkg::ADDR_STR: begin
        next_rdata = view_str;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data is reloaded only on a read strobe and then holds
  always_comb begin
    next_rdata_hold = o_rdata;
    if (i_rd) begin
      next_rdata_hold = next_rdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata_hold;
    end
  end

  // any armed falling edge while in sleep or idle
  always_comb begin
    any_fall      = |fall;
    next_wake_req = i_low_power && any_fall;
  end

  // pad outputs are registered from the per-pin next values
  // pad output value
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_out <= 8'h00;
    end else begin
      o_pin_out <= next_pin_out;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_oe <= 8'h00;
    end else begin
      o_pin_oe <= next_pin_oe;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pullup_on <= 8'h00;
    end else begin
      o_pullup_on <= next_pullup_on;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pullup_strong <= 8'h00;
    end else begin
      o_pullup_strong <= next_pullup_strong;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake_req <= 1'b0;
    end else begin
      o_wake_req <= next_wake_req;
    end
  end
endmodule : port_a_gpio_wakeup

// *** bench/pin_world.sv ***
// switches and loads seen on the port pins
`timescale 1ns/1ps
module pin_world (
  input  wire logic [7:0] i_oe,  // pad drive enable
  input  wire logic [7:0] i_out, // pad output value
  input  wire logic [7:0] i_ext, // switch level on undriven pins
  input  wire logic [7:0] i_ovr, // overload flips a driven pin
  output logic      [7:0] o_pin  // level at the pins
);
  assign o_pin = (i_oe & (i_out ^ i_ovr)) | (~i_oe & i_ext);
endmodule : pin_world

// *** bench/gpio_wake_checker.sv ***
// port relations watched at the top module's ports
`timescale 1ns/1ps
module gpio_wake_checker #(
  parameter bit EIGHT_PIN = 1'b1
) (
  input wire logic i_ref_clk, i_nrst, i_wr, i_rd, i_low_power, o_wake_req,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata, o_pin_out, o_pin_oe,
  input wire logic [7:0] o_pullup_on, o_pullup_strong
);
  localparam logic [7:0] MASK = EIGHT_PIN ? gpio_wake_pkg::MASK_8PIN
                                          : gpio_wake_pkg::MASK_4PIN;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  dir_to_oe_a: assert property (
    i_wr && i_addr == 3'h1 |-> ##2 o_pin_oe == (~$past(i_wdata, 2) & MASK))
    else $error("drive enable off");
  out_latch_a: assert property (
    i_wr && i_addr == 3'h0 |-> ##2 o_pin_out == ($past(i_wdata, 2) & MASK))
    else $error("output latch off");
  pu_follow_a: assert property (
    i_wr && i_addr == 3'h2 |-> ##2 (o_pullup_on & ~$past(i_wdata, 2)) == 8'h00)
    else $error("pull-up on while disabled");
  pu_input_a: assert property ((o_pullup_on & o_pin_oe) == 8'h00)
    else $error("pull-up on driven pin");
  strong_gate_a: assert property ((o_pullup_strong & ~o_pullup_on) == 8'h00)
    else $error("strength without pull-up");
  wake_gate_a: assert property (!i_low_power [*5] |-> !o_wake_req)
    else $error("wake outside low power");
  rd_latch_a: assert property (
    i_rd && i_addr == 3'h0 |=> ((o_rdata ^ o_pin_out) & o_pin_oe) == 8'h00)
    else $error("output pin read not latch");
  unmapped_rd_a: assert property (i_rd && i_addr > 3'h4 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : gpio_wake_checker
bind port_a_gpio_wakeup gpio_wake_checker #(.EIGHT_PIN(EIGHT_PIN)) chk (.*);

// *** bench/port_a_gpio_wakeup_tb.sv ***
// random and corner checks of the port with wake-up
`timescale 1ns/1ps
module port_a_gpio_wakeup_tb;
  logic i_ref_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_low_power = 0;
  logic o_wake_req;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, ext = 8'hFF, ovr = 8'h00, sh [8];
  logic [7:0] i_pin, o_rdata, o_pin_out, o_pin_oe, o_pullup_on, o_pullup_strong;
  logic [7:0] rd4;
  int err_count = 0, tests_run = 0, cyc = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  port_a_gpio_wakeup DUT (.*);
  pin_world far (.i_oe(o_pin_oe), .i_out(o_pin_out), .i_ext(ext),
    .i_ovr(ovr), .o_pin(i_pin));
  port_a_gpio_wakeup #(.EIGHT_PIN(1'b0)) DUT4 (.i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_rd(i_rd), .o_rdata(rd4), .i_low_power(i_low_power), .i_pin(i_pin),
    .o_pin_out(), .o_pin_oe(), .o_pullup_on(), .o_pullup_strong(),
    .o_wake_req());
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_rd(input logic [2:0] a);
    if (a == 3'h0) return (sh[0] & ~sh[1]) | (ext & sh[1]);
    if (a == 3'h4) return {7'h00, sh[4][0]};
    return (a < 3'h4) ? sh[a] : 8'h00;
  endfunction : exp_rd
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    {i_wr, i_rd, i_addr, i_wdata} = {w, !w, a, d};
    @(negedge i_ref_clk);
    {i_wr, i_rd} = 2'b00;
    if (w && a < 3'h5) sh[a] = d;
    if (!w) chk(o_rdata, exp_rd(a));
    if (!w) chk(rd4, exp_rd(a) & 8'h0F);
  endtask : bus
  task automatic fall(input logic [7:0] v, n);
    logic [7:0] c;
    c = 8'h00;
    ext = v;
    repeat (8) @(negedge i_ref_clk) c += {7'h00, o_wake_req};
    chk(c, n);
  endtask : fall
  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(67571));
    foreach (sh[k]) sh[k] = (k < 2) ? 8'hFF : 8'h00;
    repeat (16) @(negedge i_ref_clk);
    i_nrst = 1;
    repeat (4) @(negedge i_ref_clk);
    for (int a = 0; a < 8; a++) bus(0, 3'(a), 8'h00);
    repeat (80) begin
      bus(1, 3'($urandom % 6), 8'($urandom));
      {ext, ovr} = 16'($urandom);
      repeat (3) @(negedge i_ref_clk);
      chk(o_pin_oe, ~sh[1]);
      chk(o_pin_out, sh[0]);
      chk(o_pullup_on, sh[2] & sh[1]);
      chk(o_pullup_strong, sh[2] & sh[1] & {8{sh[4][0]}});
      bus(0, 3'($urandom % 8), 8'h00);
    end
    bus(1, 3'h1, 8'hFF);
    bus(1, 3'h3, 8'h01);
    ext = 8'hFF;
    i_low_power = 1;
    repeat (4) @(negedge i_ref_clk);
    fall(8'hFE, 8'h01);
    fall(8'hFC, 8'h00);
    ovr = 8'h00;
    bus(1, 3'h0, 8'hFF);
    bus(1, 3'h1, 8'hFE);
    repeat (4) @(negedge i_ref_clk);
    ovr = 8'h01;
    fall(8'hFC, 8'h00);
    ext = 8'hFF;
    ovr = 8'h00;
    bus(1, 3'h1, 8'hFF);
    i_low_power = 0;
    repeat (6) @(negedge i_ref_clk);
    fall(8'hFE, 8'h00);
    give_verdict();
  end
endmodule : port_a_gpio_wakeup_tb
